// file: rtl/fsl_consts.svh
`ifndef FSL_CONSTS_SVH
`define FSL_CONSTS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define FSL_CLK_PERIOD_NS   4
`define FSL_SETTLE_NS       1000
`define FSL_SETTLE_CYC      ((`FSL_SETTLE_NS + `FSL_CLK_PERIOD_NS - 1) / `FSL_CLK_PERIOD_NS)
`define FSL_HOST_TIMEOUT    16

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define FSL_ADDR_W          32
`define FSL_TOP_BITS        31:24
`define FSL_TOP_VALUE       8'hff
`define FSL_ID_HI_BIT       23
`define FSL_SPACE_BIT       22
`define FSL_ID_LO_BITS      21:19
`define FSL_OFFSET_W        19
`define FSL_OFFSET_BITS     18:0
`define FSL_BLOCK_BITS      18:16
`define FSL_LOW_BITS        15:0
`define FSL_SPACE_ARRAY     1'b1
`define FSL_SPACE_REG       1'b0

// ----------------------------------------------------------------
// register space
// ----------------------------------------------------------------
`define FSL_LOCK_LOW        16'h0002
`define FSL_GPI_LOW         16'h0100
`define FSL_GPI_BLOCK       3'h4
`define FSL_NUM_BLOCKS      8
`define FSL_TOP_BLOCK       7
`define FSL_GPI_W           5
`define FSL_STRAP_W         4
`define FSL_LOCK_W          3
`define FSL_BIT_WLOCK       0
`define FSL_BIT_LDOWN       1
`define FSL_BIT_RLOCK       2
`define FSL_WLOCK_RST       1'b1
`define FSL_LDOWN_RST       1'b0
`define FSL_RLOCK_RST       1'b0
`define FSL_ZERO_BYTE       8'h00
`define FSL_POLL_BIT        7
`define FSL_TOGGLE_BIT      6

`endif

// file: rtl/fsl_device.sv
`timescale 1ns/1ps
`include "fsl_consts.svh"

// How it works
// - program busy: bit 7 reads inverted written value
// - full byte valid 1 us after completion
// - erase busy: bit 7 reads zero, then one
// - polling only valid at valid addresses
// - busy: bit 6 alternates on successive reads
// - boot device straps zero, others count up
// - address id bits equal inverted strap pins
// - strap mismatch: ignore cycle, drive nothing, standby
// - bit 22 picks array or registers
// - unimplemented register locations read zero
// - register accesses ignored while busy
// - general input register shows live pin levels
// - general inputs steady across a bus cycle
// - write-locked block program/erase fails, reports error
// - top guard low protects block 7
// - main guard low protects blocks 0-6
// - write-lock set by reset
// - read-locked block reads return zero
// - read-lock cleared by reset
// - lock-down freezes lock bits until reset
// - lock byte: write, down, read bits
// - lock-down cleared only by reset

module fsl_device import fsl_pkg::*; #(
    parameter int NBLK   = `FSL_NUM_BLOCKS,
    parameter int SETTLE = `FSL_SETTLE_CYC
)(
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    fsl_if.dev                            BUS,
    input  wire logic [`FSL_STRAP_W-1:0]  STRAP_SELECT_PINS,
    input  wire logic [`FSL_GPI_W-1:0]    GENERAL_INPUT_PINS,
    input  wire logic                     TOP_BLOCK_GUARD_PIN_N,
    input  wire logic                     MAIN_GUARD_PIN_N,
    output logic      [`FSL_OFFSET_W-1:0] ARRAY_ADDR,
    input  wire logic [7:0]               ARRAY_RDATA,
    output logic                          PROG_REQ,
    output logic                          ERASE_REQ,
    output logic      [7:0]               PROG_DATA,
    input  wire logic                     ENGINE_BUSY,
    output logic                          PROT_ERROR,
    output logic                          STANDBY
);
    localparam int PW = `FSL_STRAP_W + `FSL_GPI_W + 2;

    fsl_dev_state_t           state;
    logic [PW-1:0]            pin_s1;
    logic [PW-1:0]            pin_s2;
    logic [PW-1:0]            pin_s3;
    logic [PW-1:0]            pin_q;
    logic                     cur_write;
    logic                     cur_erase;
    logic                     cur_space;
    logic [`FSL_ADDR_W-1:0]   cur_addr;
    logic [7:0]               cur_wdata;
    logic                     op_erase;
    logic [7:0]               op_data;
    logic                     toggle;
    logic                     busy_d;
    logic [$clog2(SETTLE+1)-1:0] settle_cnt;
    logic                     rsp_ack;
    logic [7:0]               rsp_rdata;
    logic [7:0]               lock_byte;
    logic [NBLK-1:0]          write_lock;
    logic [NBLK-1:0]          read_lock;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [PW-1:0] pin_raw = {STRAP_SELECT_PINS, GENERAL_INPUT_PINS,
                             TOP_BLOCK_GUARD_PIN_N, MAIN_GUARD_PIN_N};
    wire [PW-1:0] pin_agree = ~(pin_s2 ^ pin_s3);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_q  <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q  <= (pin_q & ~pin_agree) | (pin_s3 & pin_agree);
        end
    end

    wire [`FSL_STRAP_W-1:0] strap     = pin_q[PW-1 -: `FSL_STRAP_W];
    wire [`FSL_GPI_W-1:0]   gpi       = pin_q[2 +: `FSL_GPI_W];
    wire                    top_guard = pin_q[1];
    wire                    main_guard = pin_q[0];

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    wire [`FSL_STRAP_W-1:0] addr_id = {BUS.req_addr[`FSL_ID_HI_BIT],
                                       BUS.req_addr[`FSL_ID_LO_BITS]};
    wire id_match  = (addr_id == ~strap) &&
                     (BUS.req_addr[`FSL_TOP_BITS] == `FSL_TOP_VALUE);
    wire take      = BUS.req_valid && (state == FSL_DEV_IDLE);
    wire [2:0]  blk      = cur_addr[`FSL_BLOCK_BITS];
    wire [15:0] low      = cur_addr[`FSL_LOW_BITS];
    wire        is_array = (cur_space == `FSL_SPACE_ARRAY);
    wire        settling = (settle_cnt != '0);

    // guard pins are active low and OR into the write-lock bits
    wire [NBLK-1:0] guard_prot = {~top_guard, {(NBLK-1){~main_guard}}};
    wire [NBLK-1:0] prot       = write_lock | guard_prot;

    wire lock_hit = (low == `FSL_LOCK_LOW);
    wire gpi_hit  = (low == `FSL_GPI_LOW) && (blk == `FSL_GPI_BLOCK);
    wire lock_wr  = (state == FSL_DEV_ACCESS) && !is_array && cur_write &&
                    !ENGINE_BUSY && lock_hit;

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    wire poll_bit = op_erase ? 1'b0 : ~op_data[`FSL_POLL_BIT];
    wire [7:0] busy_read = {poll_bit, toggle, ARRAY_RDATA[5:0]};
    wire [7:0] settle_read = {ARRAY_RDATA[`FSL_POLL_BIT], 7'h00};
    wire [7:0] array_read = read_lock[blk] ? `FSL_ZERO_BYTE :
                            ENGINE_BUSY    ? busy_read :
                            settling       ? settle_read : ARRAY_RDATA;
    wire [7:0] reg_read   = lock_hit ? lock_byte :
                            gpi_hit  ? {3'h0, gpi} : `FSL_ZERO_BYTE;

    fsl_lock_bank #(
        .NBLK       (NBLK)
    ) u_locks (
        .clk        (CLK),
        .rstn       (RSTN),
        .wr_en      (lock_wr),
        .wr_blk     (blk),
        .wr_data    (cur_wdata[`FSL_LOCK_W-1:0]),
        .rd_blk     (blk),
        .rd_byte    (lock_byte),
        .write_lock (write_lock),
        .read_lock  (read_lock)
    );

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state     <= FSL_DEV_IDLE;
            cur_write <= 1'b0;
            cur_erase <= 1'b0;
            cur_space <= 1'b0;
            cur_addr  <= '0;
            cur_wdata <= '0;
            ARRAY_ADDR <= '0;
            STANDBY   <= 1'b1;
        end else begin
            unique case (state)
                FSL_DEV_IDLE: begin
                    if (take && id_match) begin
                        state      <= FSL_DEV_ACCESS;
                        cur_write  <= BUS.req_write;
                        cur_erase  <= BUS.req_erase;
                        cur_space  <= BUS.req_addr[`FSL_SPACE_BIT];
                        cur_addr   <= BUS.req_addr;
                        cur_wdata  <= BUS.req_wdata;
                        ARRAY_ADDR <= BUS.req_addr[`FSL_OFFSET_BITS];
                        STANDBY    <= 1'b0;
                    end else if (take) begin
                        STANDBY    <= 1'b1;
                    end
                end
                FSL_DEV_ACCESS: state <= FSL_DEV_RESP;
                FSL_DEV_RESP:   state <= FSL_DEV_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // answer, engine start and status tracking
    // ----------------------------------------------------------------
    wire acc       = (state == FSL_DEV_ACCESS);
    wire arr_wr    = acc && is_array && cur_write && !ENGINE_BUSY;
    wire blocked   = prot[blk];
    wire arr_rd    = acc && is_array && !cur_write;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rsp_ack    <= 1'b0;
            rsp_rdata  <= '0;
            PROG_REQ   <= 1'b0;
            ERASE_REQ  <= 1'b0;
            PROG_DATA  <= '0;
            PROT_ERROR <= 1'b0;
            op_erase   <= 1'b0;
            op_data    <= '0;
        end else begin
            PROG_REQ   <= arr_wr && !blocked && !cur_erase;
            ERASE_REQ  <= arr_wr && !blocked && cur_erase;
            PROT_ERROR <= arr_wr && blocked;
            if (arr_wr && !blocked) begin
                op_erase  <= cur_erase;
                op_data   <= cur_wdata;
                PROG_DATA <= cur_wdata;
            end
            if (acc) begin
                rsp_ack   <= is_array ? (!cur_write || !ENGINE_BUSY) : !ENGINE_BUSY;
                rsp_rdata <= cur_write ? `FSL_ZERO_BYTE :
                             is_array ? array_read :
                             ENGINE_BUSY ? `FSL_ZERO_BYTE : reg_read;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            toggle     <= 1'b0;
            busy_d     <= 1'b0;
            settle_cnt <= '0;
        end else begin
            busy_d <= ENGINE_BUSY;
            if (arr_rd && ENGINE_BUSY && !read_lock[blk]) begin
                toggle <= ~toggle;
            end
            if (busy_d && !ENGINE_BUSY) begin
                settle_cnt <= ($clog2(SETTLE+1))'(SETTLE);
            end else if (settling) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
        end
    end

    assign BUS.req_ready = (state == FSL_DEV_IDLE);
    assign BUS.rsp_valid = (state == FSL_DEV_RESP);
    assign BUS.rsp_ack   = rsp_ack;
    assign BUS.rsp_rdata = rsp_rdata;
endmodule

// file: rtl/fsl_host.sv
`timescale 1ns/1ps
`include "fsl_consts.svh"

module fsl_host import fsl_pkg::*; #(
    parameter int TIMEOUT = `FSL_HOST_TIMEOUT
)(
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    fsl_if.host                           BUS,
    input  wire logic                     CMD_VALID,
    output logic                          CMD_READY,
    input  wire logic                     CMD_WRITE,
    input  wire logic                     CMD_ERASE,
    input  wire logic                     CMD_REG,
    input  wire logic [`FSL_STRAP_W-1:0]  CMD_TARGET,
    input  wire logic [`FSL_OFFSET_W-1:0] CMD_OFFSET,
    input  wire logic [7:0]               CMD_WDATA,
    output logic                          RES_VALID,
    output logic                          RES_ACK,
    output logic      [7:0]               RES_DATA
);
    fsl_host_state_t          state;
    logic                     req_write;
    logic                     req_erase;
    logic [`FSL_ADDR_W-1:0]   req_addr;
    logic [7:0]               req_wdata;
    logic [$clog2(TIMEOUT+1)-1:0] wait_cnt;

    // ----------------------------------------------------------------
    // address build: id bits are the inverted target strap
    // ----------------------------------------------------------------
    wire space = CMD_REG ? `FSL_SPACE_REG : `FSL_SPACE_ARRAY;
    wire [`FSL_ADDR_W-1:0] next_addr = {`FSL_TOP_VALUE, ~CMD_TARGET[3], space,
                                        ~CMD_TARGET[2:0], CMD_OFFSET};
    wire timed_out = (wait_cnt == '0);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state     <= FSL_HOST_IDLE;
            req_write <= 1'b0;
            req_erase <= 1'b0;
            req_addr  <= '0;
            req_wdata <= '0;
            wait_cnt  <= '0;
            RES_VALID <= 1'b0;
            RES_ACK   <= 1'b0;
            RES_DATA  <= '0;
        end else begin
            RES_VALID <= 1'b0;
            unique case (state)
                FSL_HOST_IDLE: begin
                    if (CMD_VALID) begin
                        state     <= FSL_HOST_REQ;
                        req_write <= CMD_WRITE;
                        req_erase <= CMD_ERASE;
                        req_addr  <= next_addr;
                        req_wdata <= CMD_WDATA;
                    end
                end
                FSL_HOST_REQ: begin
                    if (BUS.req_ready) begin
                        state    <= FSL_HOST_WAIT;
                        wait_cnt <= ($clog2(TIMEOUT+1))'(TIMEOUT);
                    end
                end
                FSL_HOST_WAIT: begin
                    // a device that missed its strap stays silent
                    if (BUS.rsp_valid || timed_out) begin
                        state     <= FSL_HOST_IDLE;
                        RES_VALID <= 1'b1;
                        RES_ACK   <= BUS.rsp_valid && BUS.rsp_ack;
                        RES_DATA  <= BUS.rsp_valid ? BUS.rsp_rdata : `FSL_ZERO_BYTE;
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    assign CMD_READY     = (state == FSL_HOST_IDLE);
    assign BUS.req_valid = (state == FSL_HOST_REQ);
    assign BUS.req_write = req_write;
    assign BUS.req_erase = req_erase;
    assign BUS.req_addr  = req_addr;
    assign BUS.req_wdata = req_wdata;
endmodule

// file: rtl/fsl_if.sv
`timescale 1ns/1ps
`include "fsl_consts.svh"

interface fsl_if;
    logic                   req_valid;
    logic                   req_ready;
    logic                   req_write;
    logic                   req_erase;
    logic [`FSL_ADDR_W-1:0] req_addr;
    logic [7:0]             req_wdata;
    logic                   rsp_valid;
    logic                   rsp_ack;
    logic [7:0]             rsp_rdata;

    modport dev  (input req_valid, req_write, req_erase, req_addr, req_wdata,
                  output req_ready, rsp_valid, rsp_ack, rsp_rdata);
    modport host (output req_valid, req_write, req_erase, req_addr, req_wdata,
                  input req_ready, rsp_valid, rsp_ack, rsp_rdata);
endinterface

// file: rtl/fsl_lock_bank.sv
`timescale 1ns/1ps
`include "fsl_consts.svh"

module fsl_lock_bank import fsl_pkg::*; #(
    parameter int NBLK = `FSL_NUM_BLOCKS
)(
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    wr_en,
    input  wire logic [2:0]              wr_blk,
    input  wire logic [`FSL_LOCK_W-1:0]  wr_data,
    input  wire logic [2:0]              rd_blk,
    output logic      [7:0]              rd_byte,
    output logic      [NBLK-1:0]         write_lock,
    output logic      [NBLK-1:0]         read_lock
);
    logic [`FSL_LOCK_W-1:0] lock_reg [NBLK];

    // ----------------------------------------------------------------
    // per-block lock registers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NBLK; g++) begin : g_blk
            wire hit = wr_en && (wr_blk == 3'(g)) && !lock_reg[g][`FSL_BIT_LDOWN];
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    lock_reg[g][`FSL_BIT_WLOCK] <= `FSL_WLOCK_RST;
                    lock_reg[g][`FSL_BIT_LDOWN] <= `FSL_LDOWN_RST;
                    lock_reg[g][`FSL_BIT_RLOCK] <= `FSL_RLOCK_RST;
                end else if (hit) begin
                    lock_reg[g] <= wr_data;
                end
            end
            assign write_lock[g] = lock_reg[g][`FSL_BIT_WLOCK];
            assign read_lock[g]  = lock_reg[g][`FSL_BIT_RLOCK];
        end
    endgenerate

    assign rd_byte = {5'h00, lock_reg[rd_blk]};
endmodule

// file: rtl/fsl_pkg.sv
package fsl_pkg;
    typedef enum logic [1:0] {
        FSL_DEV_IDLE   = 2'b00,
        FSL_DEV_ACCESS = 2'b01,
        FSL_DEV_RESP   = 2'b10
    } fsl_dev_state_t;

    typedef enum logic [1:0] {
        FSL_HOST_IDLE = 2'b00,
        FSL_HOST_REQ  = 2'b01,
        FSL_HOST_WAIT = 2'b10
    } fsl_host_state_t;
endpackage

// file: test/fsl_status_select_and_lock_asserts.sv
`timescale 1ns/1ps
`include "fsl_consts.svh"

module fsl_bus_asserts import fsl_pkg::*; (
    input wire logic                    CLK,
    input wire logic                    RSTN,
    input wire logic [`FSL_STRAP_W-1:0] STRAP_SELECT_PINS,
    input wire logic                    req_valid,
    input wire logic                    req_ready,
    input wire logic                    req_write,
    input wire logic [`FSL_ADDR_W-1:0]  req_addr,
    input wire logic                    rsp_valid,
    input wire logic [7:0]              rsp_rdata
);
    // ----------------------------------------------------------------
    // decode of the request being taken
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    wire take = req_valid && req_ready;
    wire hit  = req_addr[31:24] == 8'hff && req_addr[23] == !STRAP_SELECT_PINS[3]
                && req_addr[21:19] == ~STRAP_SELECT_PINS[2:0];
    wire rrd  = take && hit && !req_write && !req_addr[22];
    wire lock = req_addr[15:0] == 16'h0002;
    wire gpi  = req_addr[18:16] == 3'h4 && req_addr[15:0] == 16'h0100;

    AST_ANSWER: assert property (take && hit |-> ##2 rsp_valid)
        else $error("selected request not answered two cycles after take");
    AST_MISMATCH: assert property (take && !hit |=> !rsp_valid [*4])
        else $error("request for another device was answered");
    AST_UNMAPPED: assert property (rrd && !lock && !gpi |-> ##2 rsp_rdata == 8'h00)
        else $error("unused register location not read as zero");
    AST_LOCK_RSV: assert property (rrd && lock |-> ##2 rsp_rdata[7:3] == 5'h00)
        else $error("lock byte reserved bits not zero");
    AST_GPI_RSV: assert property (rrd && gpi |-> ##2 rsp_rdata[7:5] == 3'h0)
        else $error("general input reserved bits not zero");
    AST_HOST_TOP: assert property (req_valid |-> req_addr[31:24] == 8'hff)
        else $error("host address top byte wrong");
    AST_HOST_HOLD: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr))
        else $error("host changed request before take");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
        else $error("response valid longer than one cycle");

    COV_GPI: cover property (rrd && gpi);
    COV_MISS: cover property (take && !hit);
    COV_ARRAY_WRITE: cover property (take && hit && req_write && req_addr[22]);
endmodule

// file: test/test_flash_status_select_and_lock.sv
`timescale 1ns/1ps
`include "fsl_consts.svh"

module test_flash_status_select_and_lock import fsl_pkg::*;;
    localparam logic [3:0] T = 4'h3;
    typedef struct packed {logic [7:0] dat; logic [7:0] msk; logic ack; logic tgl;} fsl_exp_t;

    logic        CLK = 1'b0, RSTN = 1'b0;
    logic        cmd_valid = 1'b0, cmd_write = 1'b0, cmd_erase = 1'b0, cmd_reg = 1'b0;
    logic [3:0]  cmd_target = 4'h0;
    logic [18:0] cmd_offset = 19'h0, array_addr, o;
    logic [7:0]  cmd_wdata = 8'h00, array_rdata, prog_data, res_data, d, a;
    logic [4:0]  gpi = 5'h00;
    logic        top_n = 1'b1, main_n = 1'b1, busy = 1'b0, prev6 = 1'b0;
    logic        cmd_ready, res_valid, res_ack, prog_req, erase_req, prot_error, standby;
    int          fail_count = 0, check_count = 0, prog_n = 0, erase_n = 0, err_n = 0;
    fsl_exp_t    q[$];
    fsl_exp_t    e;

    // ----------------------------------------------------------------
    // clock, array model, both ends
    // ----------------------------------------------------------------
    always #2 CLK = ~CLK;

    function automatic logic [7:0] arr(input logic [18:0] x);
        return x[7:0] ^ {x[18:16], 5'h0a};
    endfunction
    assign array_rdata = arr(array_addr);

    fsl_if i_fsl_if ();
    fsl_device #(.SETTLE(8)) i_fsl_device (.CLK(CLK), .RSTN(RSTN), .BUS(i_fsl_if.dev),
        .STRAP_SELECT_PINS(T), .GENERAL_INPUT_PINS(gpi), .TOP_BLOCK_GUARD_PIN_N(top_n),
        .MAIN_GUARD_PIN_N(main_n), .ARRAY_ADDR(array_addr), .ARRAY_RDATA(array_rdata),
        .PROG_REQ(prog_req), .ERASE_REQ(erase_req), .PROG_DATA(prog_data),
        .ENGINE_BUSY(busy), .PROT_ERROR(prot_error), .STANDBY(standby));
    fsl_host i_fsl_host (.CLK(CLK), .RSTN(RSTN), .BUS(i_fsl_if.host), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write), .CMD_ERASE(cmd_erase), .CMD_REG(cmd_reg),
        .CMD_TARGET(cmd_target), .CMD_OFFSET(cmd_offset), .CMD_WDATA(cmd_wdata),
        .RES_VALID(res_valid), .RES_ACK(res_ack), .RES_DATA(res_data));
    fsl_bus_asserts i_fsl_bus_asserts (.CLK(CLK), .RSTN(RSTN), .STRAP_SELECT_PINS(T),
        .req_valid(i_fsl_if.req_valid), .req_ready(i_fsl_if.req_ready),
        .req_write(i_fsl_if.req_write), .req_addr(i_fsl_if.req_addr),
        .rsp_valid(i_fsl_if.rsp_valid), .rsp_rdata(i_fsl_if.rsp_rdata));

    // ----------------------------------------------------------------
    // tasks and result watcher
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmd(input logic w, er, r, input logic [3:0] t, input logic [18:0] x,
                       input logic [7:0] wd, ex, m, input logic ak, tg);
        int i;
        @(posedge CLK);
        q.push_back('{ex, m, ak, tg});
        {cmd_valid, cmd_write, cmd_erase, cmd_reg} <= {1'b1, w, er, r};
        cmd_target <= t;
        cmd_offset <= x;
        cmd_wdata  <= wd;
        do @(posedge CLK); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (i = 0; i < 60 && res_valid !== 1'b1; i++) @(posedge CLK);
        if (res_valid !== 1'b1) check("result", 8'h00, 8'h01);
    endtask

    task automatic rd(input logic r, input logic [18:0] x, input logic [7:0] ex, m,
                      input logic ak = 1'b1, tg = 1'b0);
        cmd(1'b0, 1'b0, r, T, x, 8'h00, ex, m, ak, tg);
    endtask

    task automatic wr(input logic er, r, input logic [18:0] x, input logic [7:0] wd);
        cmd(1'b1, er, r, T, x, wd, 8'h00, 8'h00, 1'b1, 1'b0);
    endtask

    always @(posedge CLK) begin
        prog_n  += (prog_req === 1'b1);
        erase_n += (erase_req === 1'b1);
        err_n   += (prot_error === 1'b1);
        if (res_valid === 1'b1) begin
            if (q.size() == 0) begin
                check("spare result", 8'h01, 8'h00);
            end else begin
                e = q.pop_front();
                check("ack", {7'h0, res_ack}, {7'h0, e.ack});
                check("data", res_data & e.msk, e.dat & e.msk);
                if (e.tgl) check("toggle", {7'h0, res_data[6]}, {7'h0, ~prev6});
                prev6 = res_data[6];
            end
        end
    end

    initial begin
        #(20000 * 4);
        fail_count++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(63981));
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (6) @(posedge CLK);
        for (int b = 0; b < 8; b++) rd(1'b1, {b[2:0], 16'h0002}, 8'h01, 8'hff);
        rd(1'b1, 19'h40000, 8'h00, 8'hff);
        rd(1'b1, 19'h20100, 8'h00, 8'hff);
        $display("test reset_values done");
        repeat (3) begin
            gpi <= 5'($urandom);
            repeat (8) @(posedge CLK);
            rd(1'b1, 19'h40100, {3'h0, gpi}, 8'hff);
        end
        $display("test general_inputs done");
        o = {3'h5, 16'($urandom)};
        cmd(1'b0, 1'b0, 1'b0, 4'h5, o, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0);
        check("standby", {7'h0, standby}, 8'h01);
        rd(1'b0, o, arr(o), 8'hff);
        $display("test select done");
        wr(1'b0, 1'b0, 19'h20010, 8'h11);
        check("prot", err_n[7:0], 8'd1);
        check("prog", prog_n[7:0], 8'd0);
        wr(1'b0, 1'b1, 19'h20002, 8'h00);
        wr(1'b0, 1'b1, 19'h70002, 8'h00);
        top_n <= 1'b0;
        repeat (8) @(posedge CLK);
        wr(1'b0, 1'b0, 19'h70010, 8'h22);
        check("prot", err_n[7:0], 8'd2);
        top_n  <= 1'b1;
        main_n <= 1'b0;
        repeat (8) @(posedge CLK);
        wr(1'b0, 1'b0, 19'h20010, 8'h33);
        check("prot", err_n[7:0], 8'd3);
        wr(1'b0, 1'b0, 19'h70010, 8'h44);
        check("prog", prog_n[7:0], 8'd1);
        main_n <= 1'b1;
        repeat (8) @(posedge CLK);
        $display("test protection done");
        d = 8'($urandom);
        o = {3'h2, 16'($urandom)};
        a = arr(o);
        wr(1'b0, 1'b0, o, d);
        busy <= 1'b1;
        check("prog", prog_n[7:0], 8'd2);
        check("prog_data", prog_data, d);
        rd(1'b0, o, {~d[7], 1'b0, a[5:0]}, 8'hbf);
        repeat (3) rd(1'b0, o, {~d[7], 1'b0, a[5:0]}, 8'hbf, 1'b1, 1'b1);
        rd(1'b1, 19'h00002, 8'h00, 8'hff, 1'b0);
        cmd(1'b1, 1'b0, 1'b1, T, 19'h00002, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        busy <= 1'b0;
        rd(1'b0, o, {a[7], 7'h00}, 8'hff);
        repeat (20) @(posedge CLK);
        rd(1'b0, o, a, 8'hff);
        rd(1'b1, 19'h00002, 8'h01, 8'hff);
        $display("test program_status done");
        wr(1'b1, 1'b0, 19'h20000, 8'h00);
        busy <= 1'b1;
        check("erase", erase_n[7:0], 8'd1);
        rd(1'b0, o, {2'b00, a[5:0]}, 8'hbf);
        busy <= 1'b0;
        repeat (20) @(posedge CLK);
        $display("test erase_status done");
        wr(1'b0, 1'b1, 19'h10002, 8'h04);
        rd(1'b0, 19'h1abcd, 8'h00, 8'hff);
        rd(1'b1, 19'h10002, 8'h04, 8'hff);
        wr(1'b0, 1'b1, 19'h30002, 8'h03);
        wr(1'b0, 1'b1, 19'h30002, 8'h00);
        rd(1'b1, 19'h30002, 8'h03, 8'hff);
        $display("test locks done");
        RSTN <= 1'b0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (6) @(posedge CLK);
        rd(1'b1, 19'h30002, 8'h01, 8'hff);
        rd(1'b1, 19'h10002, 8'h01, 8'hff);
        @(posedge CLK);
        check("queue", 8'(q.size()), 8'h00);
        $display("test second_reset done");
        finish_test();
    end
endmodule
